// >>> inc/ldcb_pkg.sv
// constants, types and field layout for the logical device configuration bank
package ldcb_pkg;
    localparam int unsigned UNIT_COUNT = 10;
    localparam logic [7:0] IDX_UNIT_NUMBER = 8'h07;
    localparam logic [7:0] IDX_ACTIVATE = 8'h30;
    localparam logic [7:0] IDX_BASE_HIGH = 8'h60;
    localparam logic [7:0] IDX_BASE_LOW = 8'h61;
    localparam logic [7:0] IDX_IRQ_PRIMARY = 8'h70;
    localparam logic [7:0] IDX_IRQ_SECONDARY = 8'h72;
    localparam logic [7:0] IDX_VENDOR_FIRST = 8'he0;
    localparam logic [7:0] IDX_VENDOR_LAST = 8'hfe;
    localparam int unsigned ACTIVATE_BIT = 0;
    localparam int unsigned IRQ_SEL_W = 4;
    localparam logic [3:0] UNIT_POWER_EVENT = 4'h1;
    localparam logic [3:0] UNIT_SERIAL = 4'h4;
    localparam logic [3:0] UNIT_RTC = 4'h6;
    localparam logic [3:0] UNIT_KEYBOARD = 4'h7;
    localparam logic [3:0] UNIT_EC_IF = 4'h8;
    localparam logic [3:0] UNIT_MAILBOX = 4'h9;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_BASE = 16'h0000;
    localparam logic [15:0] RANGE_LOW_STD = 16'h0100;
    localparam logic [15:0] RANGE_HIGH_STD = 16'h0ff8;
    localparam logic [15:0] RANGE_HIGH_RTC = 16'h0ffe;
    localparam logic [15:0] RANGE_LOW_ZERO = 16'h0000;
    localparam logic [15:0] RANGE_HIGH_EC = 16'h0ffa;
    localparam logic [15:0] RANGE_HIGH_MBOX = 16'h0ffe;
    localparam logic [2:0] ALIGN8_MASK = 3'h7;

    // one host configuration cycle
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] index;
        logic [7:0] wdata;
    } ldcb_req_s;

    // per-unit stored state
    typedef struct packed {
        logic active;
        logic [15:0] base;
        logic [3:0] irq_pri;
        logic [3:0] irq_sec;
    } ldcb_unit_s;
endpackage

// >>> sim/ldcb_bank_monitor.sv
// port assertions for the configuration bank
module ldcb_bank_monitor #(
    parameter int unsigned UNITS = 10
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // host access
    input wire logic cfg_mode,
    input wire ldcb_pkg::ldcb_req_s req,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    // power link and override
    input wire logic pwr_wr,
    input wire logic pwr_val,
    input wire logic serial_pwr,
    input wire logic serial_override_bit,
    // results
    input wire logic [UNITS-1:0] unit_on,
    input wire logic [UNITS-1:0] decode_ok,
    input wire logic [15:0] irq_lines
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////
    rd_answer_a: assert property (cfg_mode && req.rd |=> rvalid)
        else $error("read not answered");
    no_stray_a: assert property (!(cfg_mode && req.rd) |=> !rvalid)
        else $error("answer without read");
    rdata_idle_a: assert property (!rvalid |-> rdata == 8'h00)
        else $error("read data not quiet");
    line_zero_a: assert property (irq_lines[0] == 1'b0)
        else $error("request on line zero");
    dead_units_a: assert property ((decode_ok[0] | decode_ok[2]
        | decode_ok[3] | decode_ok[5]) == 1'b0)
        else $error("reserved unit decoded");
    // two cycles of synchroniser and one of output register, plus margin
    ovr_off_a: assert property (!serial_override_bit [*4] |=> !unit_on[4])
        else $error("serial unit on while overridden");
    // stored bit then its registered mirror: two edges from pulse to pin
    pwr_link_a: assert property (pwr_wr |-> ##2 serial_pwr == $past(pwr_val, 2))
        else $error("power bit not linked");
    on_needs_act_a: assert property (!serial_pwr && !$past(serial_pwr) |-> !unit_on[4])
        else $error("serial unit on while inactive");
    quiet_irq_a: assert property ((decode_ok == '0) [*2] |-> irq_lines == 16'h0000)
        else $error("request from undecoded unit");
endmodule

// >>> sim/testbench.sv
// self-checking testbench for the configuration bank
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rst, cfg_mode, pwr_wr, pwr_val, ovr, rvalid, serial_pwr;
    ldcb_pkg::ldcb_req_s req;
    logic [9:0] unit_irq, unit_irq2, unit_on, decode_ok;
    logic [7:0] rdata;
    logic [15:0] irq_lines;
    int mismatches, compares;
    logic [7:0] gap_l [20] = '{8'h31, 8'h37, 8'h38, 8'h3f, 8'h40, 8'h5f, 8'h62, 8'h6f, 8'h71,
        8'h72, 8'h73, 8'h74, 8'h75, 8'h76, 8'ha8, 8'ha9, 8'hdf, 8'he0, 8'hfe, 8'hff};
    ldcb_bank #(.UNITS(10)) u_dut (.clk_sys(clk_sys), .rst(rst), .cfg_mode(cfg_mode), .req(req),
        .rdata(rdata), .rvalid(rvalid), .pwr_wr(pwr_wr), .pwr_val(pwr_val),
        .serial_pwr(serial_pwr), .serial_override_bit(ovr), .unit_irq(unit_irq),
        .unit_irq2(unit_irq2), .unit_on(unit_on), .decode_ok(decode_ok), .irq_lines(irq_lines));
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    // strobe stays up between back-to-back accesses, idle drops it
    task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d);
        req = '{w, ~w, idx, d};
        cyc(1);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        acc(1'b1, idx, d);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        acc(1'b0, idx, 8'h00);
        chk({7'h00, rvalid, rdata}, {8'h01, exp});
    endtask
    task automatic idle(input int n);
        req = '0;
        cyc(n);
    endtask
    task automatic close_out;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        #100us;
        mismatches++;
        close_out();
    end
    initial begin
        rst = 1'b1;
        cfg_mode = 1'b1;
        req = '0;
        pwr_wr = 1'b0;
        pwr_val = 1'b0;
        ovr = 1'b1;
        unit_irq = '0;
        unit_irq2 = '0;
        cyc(8);
        rst = 1'b0;
        chk({unit_on, serial_pwr}, 16'h0000);
        wr(8'h07, 8'h04);
        wr(8'h30, 8'hff);
        rd(8'h30, 8'h01);
        idle(4);
        chk({serial_pwr, unit_on[4]}, 16'h0003);
        pwr_val = 1'b0;
        pwr_wr = 1'b1;
        cyc(1);
        pwr_wr = 1'b0;
        rd(8'h30, 8'h00);
        idle(2);
        chk(unit_on[4], 1'b0);
        wr(8'h30, 8'h01);
        ovr = 1'b0;
        idle(5);
        chk(unit_on[4], 1'b0);
        ovr = 1'b1;
        idle(5);
        chk(unit_on[4], 1'b1);
        wr(8'h60, 8'h0f);
        wr(8'h61, 8'hf8);
        rd(8'h60, 8'h0f);
        rd(8'h61, 8'hf8);
        wr(8'h70, 8'h05);
        unit_irq[4] = 1'b1;
        idle(3);
        chk(decode_ok[4], 1'b1);
        chk(irq_lines, 16'h0020);
        // unaligned and above the ceiling
        wr(8'h61, 8'hf9);
        idle(3);
        chk(decode_ok[4], 1'b0);
        chk(irq_lines, 16'h0000);
        wr(8'h61, 8'hf8);
        for (int n = 0; n < 16; n++) begin
            wr(8'h70, 8'(n));
            idle(3);
            chk(irq_lines, 16'(1 << n) & 16'hfffe);
        end
        foreach (gap_l[i]) begin
            wr(gap_l[i], 8'hff);
            rd(gap_l[i], 8'h00);
        end
        wr(8'h07, 8'h07);
        rd(8'h60, 8'h00);
        wr(8'h72, 8'h03);
        rd(8'h72, 8'h03);
        wr(8'h30, 8'h01);
        unit_irq2[7] = 1'b1;
        idle(3);
        chk({6'h00, unit_on}, 16'h0090);
        chk(irq_lines, 16'h8008);
        // unit numbers past the last bank reach nothing
        wr(8'h07, 8'h0b);
        wr(8'h30, 8'h01);
        rd(8'h30, 8'h00);
        rd(8'h07, 8'h0b);
        wr(8'h07, 8'h07);
        cfg_mode = 1'b0;
        wr(8'h30, 8'h00);
        acc(1'b0, 8'h30, 8'h00);
        chk({5'h00, rvalid, unit_on}, 16'h0090);
        idle(1);
        cfg_mode = 1'b1;
        rd(8'h30, 8'h01);
        idle(2);
        close_out();
    end
endmodule
bind ldcb_bank ldcb_bank_monitor #(.UNITS(UNITS)) u_mon (.clk_sys(clk_sys), .rst(rst),
    .cfg_mode(cfg_mode), .req(req), .rdata(rdata), .rvalid(rvalid), .pwr_wr(pwr_wr),
    .pwr_val(pwr_val), .serial_pwr(serial_pwr), .serial_override_bit(serial_override_bit),
    .unit_on(unit_on), .decode_ok(decode_ok), .irq_lines(irq_lines));

// >>> verilog/ldcb_bank.sv
// logical device configuration bank: unit select, per-unit banks, enables
//////////////////////////////////////////////////////////////////////////////
module ldcb_bank #(
    parameter int unsigned UNITS = ldcb_pkg::UNIT_COUNT
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // configuration state and host register access
    input wire logic cfg_mode,
    input wire ldcb_pkg::ldcb_req_s req,
    output logic [7:0] rdata,
    output logic rvalid,
    // linked power-control bit of the serial unit
    input wire logic pwr_wr,
    input wire logic pwr_val,
    output logic serial_pwr,
    // embedded controller override, from the controller's own domain
    input wire logic serial_override_bit,
    // per-unit interrupt requests from the units
    input wire logic [UNITS-1:0] unit_irq,
    input wire logic [UNITS-1:0] unit_irq2,
    // results towards the rest of the chip
    output logic [UNITS-1:0] unit_on,
    output logic [UNITS-1:0] decode_ok,
    output logic [15:0] irq_lines
);
    ldcb_pkg::ldcb_unit_s st [UNITS];
    logic [3:0] unit_q;
    logic ovr_meta_q;
    logic ovr_q;
    logic [UNITS-1:0] in_range;
    logic [UNITS-1:0] on_d;
    logic [15:0] irq_d;
    logic [7:0] rdata_d;
    logic unit_ok;
    ldcb_pkg::ldcb_unit_s cur;

    //////////////////////////////////////////////////////////////////////////
    // unit number select

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            unit_q <= 4'h0;
        end else if (cfg_mode && req.wr && req.index == ldcb_pkg::IDX_UNIT_NUMBER) begin
            unit_q <= req.wdata[3:0];
        end
    end

    // override bit crosses from another domain
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ovr_meta_q <= 1'b0;
            ovr_q <= 1'b0;
        end else begin
            ovr_meta_q <= serial_override_bit;
            ovr_q <= ovr_meta_q;
        end
    end

    assign unit_ok = (32'(unit_q) < UNITS);

    //////////////////////////////////////////////////////////////////////////
    // per-unit banks

    for (genvar u = 0; u < UNITS; u++) begin : g_unit
        logic sel_u;
        logic pwr_u;
        // only the selected unit sees data port writes, and only in config state
        assign sel_u = cfg_mode && unit_ok && (unit_q == 4'(u));
        assign pwr_u = pwr_wr && (4'(u) == ldcb_pkg::UNIT_SERIAL);
        ldcb_unit_bank #(
            .UNIT_NUM(4'(u))
        ) u_bank (
            .clk_sys(clk_sys),
            .rst(rst),
            .sel(sel_u),
            .req(req),
            .pwr_wr(pwr_u),
            .pwr_val(pwr_val),
            .state(st[u])
        );
    end

    //////////////////////////////////////////////////////////////////////////
    // base range check per unit; fixed-base units are always in range

    function automatic logic range_ok(input logic [3:0] n, input logic [15:0] b);
        logic ok;
        ok = 1'b0;
        unique case (n)
            ldcb_pkg::UNIT_POWER_EVENT, ldcb_pkg::UNIT_SERIAL: begin
                ok = (b >= ldcb_pkg::RANGE_LOW_STD) && (b <= ldcb_pkg::RANGE_HIGH_STD)
                    && ((b[2:0] & ldcb_pkg::ALIGN8_MASK) == 3'h0);
            end
            ldcb_pkg::UNIT_RTC: begin
                ok = (b >= ldcb_pkg::RANGE_LOW_STD) && (b <= ldcb_pkg::RANGE_HIGH_RTC);
            end
            ldcb_pkg::UNIT_KEYBOARD: begin
                ok = 1'b1;
            end
            ldcb_pkg::UNIT_EC_IF: begin
                ok = (b >= ldcb_pkg::RANGE_LOW_ZERO) && (b <= ldcb_pkg::RANGE_HIGH_EC);
            end
            ldcb_pkg::UNIT_MAILBOX: begin
                ok = (b >= ldcb_pkg::RANGE_LOW_ZERO) && (b <= ldcb_pkg::RANGE_HIGH_MBOX);
            end
            default: begin
                ok = 1'b0;
            end
        endcase
        return ok;
    endfunction

    always_comb begin
        in_range = '0;
        on_d = '0;
        irq_d = 16'h0000;
        for (int u = 0; u < UNITS; u++) begin
            in_range[u] = range_ok(4'(u), st[u].base);
            on_d[u] = st[u].active;
            if (4'(u) == ldcb_pkg::UNIT_SERIAL) begin
                on_d[u] = st[u].active && ovr_q;
            end
            // decode gating keeps out-of-range units silent
            if (on_d[u] && in_range[u]) begin
                if (unit_irq[u] && st[u].irq_pri != 4'h0) begin
                    irq_d[st[u].irq_pri] = 1'b1;
                end
                if (unit_irq2[u] && st[u].irq_sec != 4'h0) begin
                    irq_d[st[u].irq_sec] = 1'b1;
                end
            end
        end
        irq_d[0] = 1'b0;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            unit_on <= '0;
            decode_ok <= '0;
            irq_lines <= 16'h0000;
        end else begin
            unit_on <= on_d;
            decode_ok <= on_d & in_range;
            irq_lines <= irq_d;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // read decode; everything not implemented reads zero

    always_comb begin
        cur = unit_ok ? st[unit_q] : '0;
        rdata_d = ldcb_pkg::RESET_BYTE;
        if (req.index == ldcb_pkg::IDX_UNIT_NUMBER) begin
            rdata_d = {4'h0, unit_q};
        end else if (unit_ok) begin
            unique case (req.index)
                ldcb_pkg::IDX_ACTIVATE: rdata_d = {7'h00, cur.active};
                ldcb_pkg::IDX_BASE_HIGH: rdata_d = cur.base[15:8];
                ldcb_pkg::IDX_BASE_LOW: rdata_d = cur.base[7:0];
                ldcb_pkg::IDX_IRQ_PRIMARY: rdata_d = {4'h0, cur.irq_pri};
                ldcb_pkg::IDX_IRQ_SECONDARY: rdata_d = {4'h0, cur.irq_sec};
                // 0x31-0x5f, 0x62-0x6f, 0x71, 0x73-0xdf, 0xe0-0xff
                default: rdata_d = ldcb_pkg::RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            rvalid <= cfg_mode && req.rd;
            rdata <= (cfg_mode && req.rd) ? rdata_d : 8'h00;
        end
    end

    // serial power-control bit mirrors the serial unit's activate bit
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            serial_pwr <= 1'b0;
        end else begin
            serial_pwr <= st[ldcb_pkg::UNIT_SERIAL].active;
        end
    end
endmodule

// >>> verilog/ldcb_unit_bank.sv
// one unit's stored configuration registers
module ldcb_unit_bank #(
    parameter logic [3:0] UNIT_NUM = 4'h0
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // write port, already qualified for this unit
    input wire logic sel,
    input wire ldcb_pkg::ldcb_req_s req,
    // power-control bit write path from the global register
    input wire logic pwr_wr,
    input wire logic pwr_val,
    // stored state
    output ldcb_pkg::ldcb_unit_s state
);
    ldcb_pkg::ldcb_unit_s st_q;
    logic has_sec;

    assign has_sec = (UNIT_NUM == ldcb_pkg::UNIT_KEYBOARD);
    assign state = st_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_q <= '0;
        end else if (pwr_wr) begin
            st_q.active <= pwr_val;
        end else if (sel && req.wr) begin
            unique case (req.index)
                ldcb_pkg::IDX_ACTIVATE: begin
                    st_q.active <= req.wdata[ldcb_pkg::ACTIVATE_BIT];
                end
                ldcb_pkg::IDX_BASE_HIGH: begin
                    st_q.base[15:8] <= req.wdata;
                end
                ldcb_pkg::IDX_BASE_LOW: begin
                    st_q.base[7:0] <= req.wdata;
                end
                ldcb_pkg::IDX_IRQ_PRIMARY: begin
                    st_q.irq_pri <= req.wdata[3:0];
                end
                ldcb_pkg::IDX_IRQ_SECONDARY: begin
                    if (has_sec) begin
                        st_q.irq_sec <= req.wdata[3:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end
endmodule
